// file: hw/tmrcc_defs.svh
// Purpose: Offsets, field positions and reset values of the timer control/counter core
// Assumes: 6-bit byte address, 16-bit register data
// Notes:   Definitions only
`ifndef TMRCC_DEFS_SVH
`define TMRCC_DEFS_SVH

// Register offsets
`define TMRCC_OFS_CONTROL     6'h00
`define TMRCC_OFS_COUNT       6'h10
`define TMRCC_OFS_DIV_EXT     6'h20

// Control field positions
`define TMRCC_FLD_FLAG        0
`define TMRCC_FLD_IEN         1
`define TMRCC_FLD_CLEAR       2
`define TMRCC_FLD_MODE_LO     4
`define TMRCC_FLD_MODE_HI     5
`define TMRCC_FLD_DIV_LO      6
`define TMRCC_FLD_DIV_HI      7
`define TMRCC_FLD_SRC_LO      8
`define TMRCC_FLD_SRC_HI      9
`define TMRCC_FLD_LEN_LO      11
`define TMRCC_FLD_LEN_HI      12
`define TMRCC_FLD_GRP_LO      13
`define TMRCC_FLD_GRP_HI      14
`define TMRCC_FLD_EXT_HI      2

// Reset values
`define TMRCC_RST_CONTROL     16'h0000
`define TMRCC_RST_COUNT       16'h0000
`define TMRCC_RST_DIV_EXT     3'h0
`define TMRCC_RST_LATCH       16'h0000

// Counter maxima per length code
`define TMRCC_MAX_16          16'hffff
`define TMRCC_MAX_12          16'h0fff
`define TMRCC_MAX_10          16'h03ff
`define TMRCC_MAX_8           16'h00ff

`endif

// file: hw/tmrcc_pkg.sv
// Purpose: Types of the timer control/counter core
// Assumes: Used with tmrcc_defs.svh
// Notes:   Enumerations only
package tmrcc_pkg;

    typedef enum logic [1:0] {
        TMRCC_MODE_STOP,
        TMRCC_MODE_UP,
        TMRCC_MODE_CONT,
        TMRCC_MODE_UPDN
    } tmrcc_mode_t;

    typedef enum logic {
        TMRCC_DIR_UP,
        TMRCC_DIR_DOWN
    } tmrcc_dir_t;

    typedef enum logic [1:0] {
        TMRCC_SRC_EXT,
        TMRCC_SRC_AUX,
        TMRCC_SRC_SUBSYS,
        TMRCC_SRC_ALT
    } tmrcc_src_t;

endpackage

// file: hw/tmrcc_top.sv
// Purpose: Control and counter core of a 16-bit timer with grouped compare shadow latches
// Assumes: Clock sources and channel signals are synchronous to i_clock
// Notes:   Register reads answer one cycle after the read strobe
`timescale 1ns/1ps
`include "tmrcc_defs.svh"

module tmrcc_top
    import tmrcc_pkg::*;
(
    input  wire logic          i_clock,
    input  wire logic          i_srst,
    input  wire logic [5:0]    i_addr,
    input  wire logic [15:0]   i_wdata,
    input  wire logic          i_wr,
    input  wire logic          i_rd,
    output logic      [15:0]   o_rdata,
    input  wire logic          i_external_timer_clock,
    input  wire logic          i_auxiliary_clock,
    input  wire logic          i_subsystem_master_clock,
    input  wire logic          i_alternate_input_clock,
    input  wire logic [111:0]  i_capture_compare_value,
    input  wire logic [13:0]   i_latch_load_select,
    input  wire logic [6:0]    i_capture_compare_write,
    output logic      [111:0]  o_compare_shadow_latch,
    output logic      [15:0]   o_counter_value,
    output logic               o_overflow_irq_request
);

    // Limit of the counter for a length code
    function automatic logic [15:0] len_max(input logic [1:0] len);
        case (len)
            2'h0:    len_max = `TMRCC_MAX_16;
            2'h1:    len_max = `TMRCC_MAX_12;
            2'h2:    len_max = `TMRCC_MAX_10;
            default: len_max = `TMRCC_MAX_8;
        endcase
    endfunction

    // Terminal count of the first divider stage
    function automatic logic [2:0] div_limit(input logic [1:0] code);
        case (code)
            2'h0:    div_limit = 3'h0;
            2'h1:    div_limit = 3'h1;
            2'h2:    div_limit = 3'h3;
            default: div_limit = 3'h7;
        endcase
    endfunction

    // Channel whose load select governs latch c under a group code
    function automatic logic [2:0] ctl_chan(input logic [1:0] grp, input logic [2:0] c);
        case (grp)
            2'h0:    ctl_chan = c;
            2'h1:    ctl_chan = (c == 3'h0) ? 3'h0 : (c[0] ? c : c - 3'h1);
            2'h2:    ctl_chan = (c == 3'h0) ? 3'h0 : ((c <= 3'h3) ? 3'h1 : 3'h4);
            default: ctl_chan = 3'h1;
        endcase
    endfunction

    // Control register fields
    logic [1:0]      grp_q;
    logic [1:0]      len_q;
    tmrcc_src_t      src_q;
    logic [1:0]      div_q;
    tmrcc_mode_t     mode_q;
    logic            ien_q;
    logic            flag_q;
    logic [2:0]      ext_q;

    // Counter and divider state
    logic [15:0]     cnt_q;
    logic [15:0]     cnt_d;
    tmrcc_dir_t      dir_q;
    tmrcc_dir_t      dir_d;
    logic [2:0]      id_cnt_q;
    logic [2:0]      ex_cnt_q;
    logic            src_prev_q;
    logic            src_lvl;
    logic            src_edge;
    logic            tick;
    logic            wrap;

    logic [15:0]     latch_q [7];
    logic [6:0]      ev_ch;
    logic [6:0]      latch_ev;
    logic [15:0]     max_v;
    logic [15:0]     period_v;
    logic            zero_hit;
    logic            period_hit;

    logic            wr_ctl;
    logic            wr_cnt;
    logic            clr;

    assign wr_ctl = i_wr && (i_addr == `TMRCC_OFS_CONTROL);
    assign wr_cnt = i_wr && (i_addr == `TMRCC_OFS_COUNT);
    assign clr    = wr_ctl && i_wdata[`TMRCC_FLD_CLEAR];
    assign max_v    = len_max(len_q);
    assign period_v = latch_q[0] & max_v;

    // Control fields; clear is a pulse and is never stored
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            grp_q  <= 2'h0;
            len_q  <= 2'h0;
            src_q  <= TMRCC_SRC_EXT;
            div_q  <= 2'h0;
            mode_q <= TMRCC_MODE_STOP;
            ien_q  <= 1'b0;
        end else if (wr_ctl) begin
            grp_q  <= i_wdata[`TMRCC_FLD_GRP_HI:`TMRCC_FLD_GRP_LO];
            len_q  <= i_wdata[`TMRCC_FLD_LEN_HI:`TMRCC_FLD_LEN_LO];
            src_q  <= tmrcc_src_t'(i_wdata[`TMRCC_FLD_SRC_HI:`TMRCC_FLD_SRC_LO]);
            div_q  <= i_wdata[`TMRCC_FLD_DIV_HI:`TMRCC_FLD_DIV_LO];
            mode_q <= tmrcc_mode_t'(i_wdata[`TMRCC_FLD_MODE_HI:`TMRCC_FLD_MODE_LO]);
            ien_q  <= i_wdata[`TMRCC_FLD_IEN];
        end
    end

    // Divider extension register
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            ext_q <= `TMRCC_RST_DIV_EXT;
        end else if (i_wr && (i_addr == `TMRCC_OFS_DIV_EXT)) begin
            ext_q <= i_wdata[`TMRCC_FLD_EXT_HI:0];
        end
    end

    // Source select; sources are sampled, so they must be no faster than half the clock
    always_comb begin
        case (src_q)
            TMRCC_SRC_EXT:    src_lvl = i_external_timer_clock;
            TMRCC_SRC_AUX:    src_lvl = i_auxiliary_clock;
            TMRCC_SRC_SUBSYS: src_lvl = i_subsystem_master_clock;
            default:          src_lvl = i_alternate_input_clock;
        endcase
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            src_prev_q <= 1'b0;
        end else begin
            src_prev_q <= src_lvl;
        end
    end

    assign src_edge = src_lvl && !src_prev_q;
    // Tick when both divider stages reach their terminal counts
    assign tick = src_edge && (id_cnt_q >= div_limit(div_q)) && (ex_cnt_q >= ext_q);

    // Cascaded dividers; stopped mode freezes them to save toggling
    always_ff @(posedge i_clock) begin
        if (i_srst || clr) begin
            id_cnt_q <= 3'h0;
            ex_cnt_q <= 3'h0;
        end else if (src_edge && (mode_q != TMRCC_MODE_STOP)) begin
            if (id_cnt_q >= div_limit(div_q)) begin
                id_cnt_q <= 3'h0;
                ex_cnt_q <= (ex_cnt_q >= ext_q) ? 3'h0 : ex_cnt_q + 3'h1;
            end else begin
                id_cnt_q <= id_cnt_q + 3'h1;
            end
        end
    end

    // Next count per mode
    always_comb begin
        cnt_d = cnt_q;
        dir_d = dir_q;
        wrap  = 1'b0;
        if (tick) begin
            case (mode_q)
                TMRCC_MODE_UP: begin
                    if (cnt_q >= period_v) begin
                        cnt_d = 16'h0000;
                        wrap  = (cnt_q != 16'h0000);
                    end else begin
                        cnt_d = cnt_q + 16'h0001;
                    end
                end
                TMRCC_MODE_CONT: begin
                    if (cnt_q >= max_v) begin
                        cnt_d = 16'h0000;
                        wrap  = 1'b1;
                    end else begin
                        cnt_d = cnt_q + 16'h0001;
                    end
                end
                TMRCC_MODE_UPDN: begin
                    if (dir_q == TMRCC_DIR_UP) begin
                        if (cnt_q < period_v) begin
                            cnt_d = cnt_q + 16'h0001;
                        end else if (cnt_q != 16'h0000) begin
                            dir_d = TMRCC_DIR_DOWN;
                            cnt_d = cnt_q - 16'h0001;
                        end
                    end else if (cnt_q <= 16'h0001) begin
                        cnt_d = 16'h0000;
                        dir_d = TMRCC_DIR_UP;
                        wrap  = (cnt_q == 16'h0001);
                    end else begin
                        cnt_d = cnt_q - 16'h0001;
                    end
                end
                default: begin
                    cnt_d = cnt_q;
                end
            endcase
        end
    end

    // Counter: clear beats software write, which beats counting
    always_ff @(posedge i_clock) begin
        if (i_srst || clr) begin
            cnt_q <= `TMRCC_RST_COUNT;
            dir_q <= TMRCC_DIR_UP;
        end else if (wr_cnt) begin
            cnt_q <= i_wdata;
        end else begin
            cnt_q <= cnt_d;
            dir_q <= dir_d;
        end
    end

    // Overflow flag; a wrap beats a control write without clear; clear or a count write in the same cycle drops the wrap
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            flag_q <= 1'b0;
        end else if (wrap && !clr && !wr_cnt) begin
            flag_q <= 1'b1;
        end else if (wr_ctl) begin
            flag_q <= i_wdata[`TMRCC_FLD_FLAG];
        end
    end

    // Interrupt request gated by the enable
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            o_overflow_irq_request <= 1'b0;
        end else begin
            o_overflow_irq_request <= flag_q && ien_q;
        end
    end

    assign zero_hit   = tick && (mode_q != TMRCC_MODE_STOP) && (cnt_d == 16'h0000)
                        && (cnt_q != 16'h0000);
    assign period_hit = tick && (mode_q != TMRCC_MODE_STOP) && (cnt_d == period_v)
                        && (cnt_q != cnt_d);

    // Load event selected by each channel's own load select
    always_comb begin
        ev_ch = 7'h00;
        for (int k = 0; k < 7; k++) begin
            case (i_latch_load_select[2*k +: 2])
                2'h0: ev_ch[k] = i_capture_compare_write[k];
                2'h1: ev_ch[k] = zero_hit;
                2'h2: ev_ch[k] = zero_hit || ((mode_q == TMRCC_MODE_UPDN) && period_hit);
                default: ev_ch[k] = tick && (mode_q != TMRCC_MODE_STOP)
                                    && (cnt_d == latch_q[k]) && (cnt_q != cnt_d);
            endcase
        end
    end

    // Group routing: each latch takes the event of its controlling channel
    always_comb begin
        latch_ev = 7'h00;
        for (int c = 0; c < 7; c++) begin
            latch_ev[c] = ev_ch[ctl_chan(grp_q, 3'(c))];
        end
    end

    // Shadow latches, each loaded from its own channel value
    always_ff @(posedge i_clock) begin
        for (int c = 0; c < 7; c++) begin
            if (i_srst) begin
                latch_q[c] <= `TMRCC_RST_LATCH;
            end else if (latch_ev[c]) begin
                latch_q[c] <= i_capture_compare_value[16*c +: 16];
            end
        end
    end

    // Output copies of the latches and counter
    always_comb begin
        for (int c = 0; c < 7; c++) begin
            o_compare_shadow_latch[16*c +: 16] = latch_q[c];
        end
    end

    assign o_counter_value = cnt_q;

    // Read data one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            o_rdata <= 16'h0000;
        end else if (i_rd) begin
            if (i_addr == `TMRCC_OFS_CONTROL) begin
                o_rdata <= {1'b0, grp_q, len_q, 1'b0, src_q, div_q, mode_q,
                            1'b0, 1'b0, ien_q, flag_q};
            end else if (i_addr == `TMRCC_OFS_COUNT) begin
                o_rdata <= cnt_q;
            end else if (i_addr == `TMRCC_OFS_DIV_EXT) begin
                o_rdata <= {13'h0000, ext_q};
            end else begin
                o_rdata <= 16'h0000;
            end
        end else begin
            o_rdata <= 16'h0000;
        end
    end

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_srst);

    sequence ctl_read_s;
        i_rd && (i_addr == `TMRCC_OFS_CONTROL);
    endsequence

    ctl_reserved_zero_a: assert property (ctl_read_s |=> (o_rdata[15] == 1'b0)
        && (o_rdata[10] == 1'b0) && (o_rdata[3] == 1'b0))
        else $error("reserved control bit read as one");

    clear_reads_zero_a: assert property (ctl_read_s |=> o_rdata[2] == 1'b0)
        else $error("clear bit read back as one");

    clear_resets_a: assert property (clr |=> (cnt_q == 16'h0000)
        && (id_cnt_q == 3'h0) && (dir_q == TMRCC_DIR_UP))
        else $error("clear did not reset counter state");

    stop_holds_a: assert property ((mode_q == TMRCC_MODE_STOP) && !wr_cnt && !clr
        |=> $stable(cnt_q))
        else $error("counter moved in stop mode");

    up_restart_a: assert property (tick && (mode_q == TMRCC_MODE_UP)
        && (cnt_q >= period_v) && !wr_cnt && !clr |=> cnt_q == 16'h0000)
        else $error("up mode did not restart at period");

    cont_wrap_a: assert property (tick && (mode_q == TMRCC_MODE_CONT) && (cnt_q == max_v)
        && !wr_cnt && !clr && !wr_ctl |=> (cnt_q == 16'h0000) && flag_q)
        else $error("continuous mode did not wrap at length maximum");

    updn_turn_a: assert property (tick && (mode_q == TMRCC_MODE_UPDN)
        && (dir_q == TMRCC_DIR_UP) && (cnt_q == period_v) && (cnt_q != 16'h0000)
        && !wr_cnt && !clr |=> (dir_q == TMRCC_DIR_DOWN) && (cnt_q == $past(cnt_q) - 16'h0001))
        else $error("up/down mode did not turn at period");

    length_max_a: assert property ((len_q == 2'h3) && (mode_q == TMRCC_MODE_CONT)
        && (cnt_q <= max_v) && !wr_cnt && !wr_ctl |=> cnt_q <= 16'h00ff)
        else $error("counter exceeded 8-bit length");

    divider_two_a: assert property (tick && (div_q == 2'h1) && (ext_q == 3'h0)
        && (mode_q != TMRCC_MODE_STOP) && !clr |=> (id_cnt_q == 3'h0) && (ex_cnt_q == 3'h0))
        else $error("divide-by-two stage did not restart after tick");

    irq_gate_a: assert property (!ien_q ##1 !ien_q |-> !o_overflow_irq_request)
        else $error("overflow request without enable");

    flag_set_a: assert property (wrap && !clr && !wr_cnt |=> flag_q ##1 1'b1)
        else $error("overflow flag not set on wrap");

    count_write_a: assert property (wr_cnt && !clr |=> cnt_q == $past(i_wdata))
        else $error("counter write not taken");

    group_indep_a: assert property ((grp_q == 2'h0) && ev_ch[2] && !ev_ch[1]
        |=> latch_q[2] == $past(i_capture_compare_value[47:32]))
        else $error("independent latch not loaded");

    group_pairs_a: assert property ((grp_q == 2'h1) && ev_ch[1]
        |=> latch_q[2] == $past(i_capture_compare_value[47:32]))
        else $error("paired latch not loaded by channel one");

    group_triples_a: assert property ((grp_q == 2'h2) && ev_ch[4]
        |=> latch_q[6] == $past(i_capture_compare_value[111:96]))
        else $error("triple latch not loaded by channel four");

    group_all_a: assert property ((grp_q == 2'h3) && ev_ch[1]
        |=> latch_q[0] == $past(i_capture_compare_value[15:0]))
        else $error("period latch not loaded by channel one");

endmodule

// file: bench/tmrcc_top_tb.sv
// Purpose: Self-checking bench for the timer control/counter core
// Assumes: Clock sources pulsed by the bench, one rising edge per two cycles
// Notes:   Register rows first, then counting, latch grouping and reset cases
`timescale 1ns/1ps
`include "tmrcc_defs.svh"

module tmrcc_top_tb;
    import tmrcc_pkg::*;

    typedef struct packed {
        logic [5:0]  a;
        logic [15:0] w;
        logic [15:0] r;
    } tmrcc_row_t;

    logic          i_clock;
    logic          i_srst;
    logic          i_wr;
    logic          i_rd;
    logic [5:0]    i_addr;
    logic [15:0]   i_wdata;
    logic [3:0]    src;
    logic [111:0]  ccv;
    logic [13:0]   lsel;
    logic [6:0]    ccw;
    logic [111:0]  o_compare_shadow_latch;
    logic [15:0]   o_rdata;
    logic [15:0]   o_counter_value;
    logic          o_overflow_irq_request;
    logic [15:0]   rd_val;
    logic [15:0]   exp_l [7];
    int            n_mismatch;
    int            total_checks;

    // Writes, then readback; reserved and clear bits must come back zero
    tmrcc_row_t    rows [8] = '{'{6'h00, 16'hffff, 16'h7bf3}, '{6'h00, 16'h8408, 16'h0000},
                                '{6'h00, 16'h0000, 16'h0000}, '{6'h10, 16'h1234, 16'h1234},
                                '{6'h10, 16'hffff, 16'hffff}, '{6'h20, 16'hffff, 16'h0007},
                                '{6'h20, 16'h0000, 16'h0000}, '{6'h3e, 16'hbeef, 16'h0000}};
    int            idc [6] = '{0, 1, 2, 3, 0, 1};
    logic [15:0]   exc [6] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0002, 16'h0002};
    logic [15:0]   dex [6] = '{16'h0018, 16'h000c, 16'h0006, 16'h0003, 16'h0008, 16'h0004};
    logic [15:0]   mx [4]  = '{16'hffff, 16'h0fff, 16'h03ff, 16'h00ff};

    tmrcc_top dut (
        .i_clock                  (i_clock),
        .i_srst                   (i_srst),
        .i_addr                   (i_addr),
        .i_wdata                  (i_wdata),
        .i_wr                     (i_wr),
        .i_rd                     (i_rd),
        .o_rdata                  (o_rdata),
        .i_external_timer_clock   (src[0]),
        .i_auxiliary_clock        (src[1]),
        .i_subsystem_master_clock (src[2]),
        .i_alternate_input_clock  (src[3]),
        .i_capture_compare_value  (ccv),
        .i_latch_load_select      (lsel),
        .i_capture_compare_write  (ccw),
        .o_compare_shadow_latch   (o_compare_shadow_latch),
        .o_counter_value          (o_counter_value),
        .o_overflow_irq_request   (o_overflow_irq_request)
    );

    // Free-running 100 MHz clock
    initial begin
        i_clock = 1'b0;
        forever #5 i_clock = ~i_clock;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        @(posedge i_clock);
        i_addr  <= a;
        i_wdata <= d;
        i_wr    <= 1'b1;
        @(posedge i_clock);
        i_wr    <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [5:0] a);
        @(posedge i_clock);
        i_addr <= a;
        i_rd   <= 1'b1;
        @(posedge i_clock);
        i_rd   <= 1'b0;
        #1;
        rd_val = o_rdata;
    endtask

    // n rising edges on the masked sources, then idle so every tick lands
    task automatic pulse(input logic [3:0] m, input int n);
        repeat (n) begin
            @(posedge i_clock);
            src <= m;
            @(posedge i_clock);
            src <= 4'h0;
        end
        repeat (3) @(posedge i_clock);
        #1;
    endtask

    // Channel whose write pulse reloads latch l under group g
    function automatic int ctrl(input int g, input int l);
        case (g)
            0: return l;
            1: return (l == 0) ? 0 : l - ((l + 1) % 2);
            2: return (l == 0) ? 0 : ((l < 4) ? 1 : 4);
            default: return 1;
        endcase
    endfunction

    // Hang guard, far beyond the roughly 800 cycles the tests take
    initial begin
        #200000;
        n_mismatch++;
        tally_and_finish();
    end

    initial begin
        i_srst       = 1'b1;
        i_wr         = 1'b0;
        i_rd         = 1'b0;
        i_addr       = 6'h00;
        i_wdata      = 16'h0000;
        src          = 4'h0;
        ccv          = '0;
        lsel         = 14'h0000;
        ccw          = 7'h00;
        n_mismatch   = 0;
        total_checks = 0;
        foreach (exp_l[l]) exp_l[l] = 16'h0000;
        repeat (8) @(posedge i_clock);
        i_srst <= 1'b0;
        #1;
        chk(o_counter_value, 16'h0000);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].w);
            rd(rows[i].a);
            chk(rd_val, rows[i].r);
        end
        @(posedge i_clock);
        #1;
        chk(o_rdata, 16'h0000);
        // Stopped counter ignores every source
        wr(6'h10, 16'h0005);
        pulse(4'hf, 4);
        chk(o_counter_value, 16'h0005);
        // Only the selected source advances the count
        for (int s = 0; s < 4; s++) begin
            wr(6'h00, 16'h0024 | 16'(s << 8));
            pulse(~(4'h1 << s), 3);
            chk(o_counter_value, 16'h0000);
            pulse(4'h1 << s, 3);
            chk(o_counter_value, 16'h0003);
        end
        // 24 source edges through each first-stage divider code with extension 0, and codes 0 and 1 with extension 2
        for (int d = 0; d < 6; d++) begin
            wr(6'h20, exc[d]);
            wr(6'h00, 16'h0024 | 16'(idc[d] << 6));
            pulse(4'h1, 24);
            chk(o_counter_value, dex[d]);
        end
        wr(6'h20, 16'h0000);
        // Wrap at each length maximum, with overflow request
        for (int l = 0; l < 4; l++) begin
            wr(6'h00, 16'h0026 | 16'(l << 11));
            wr(6'h10, mx[l] - 16'h0001);
            pulse(4'h1, 1);
            chk(o_counter_value, mx[l]);
            chk(o_overflow_irq_request, 16'h0000);
            pulse(4'h1, 1);
            chk(o_counter_value, 16'h0000);
            chk(o_overflow_irq_request, 16'h0001);
        end
        // Software-written flag, gated by the enable
        wr(6'h00, 16'h0001);
        pulse(4'h0, 0);
        chk(o_overflow_irq_request, 16'h0000);
        rd(6'h00);
        chk(rd_val, 16'h0001);
        wr(6'h00, 16'h0003);
        pulse(4'h0, 0);
        chk(o_overflow_irq_request, 16'h0001);
        wr(6'h00, 16'h0002);
        pulse(4'h0, 0);
        chk(o_overflow_irq_request, 16'h0000);
        // Each group setting, a write pulse on every channel in turn
        for (int g = 0; g < 4; g++) begin
            wr(6'h00, 16'(g << 13));
            for (int k = 0; k < 7; k++) begin
                @(posedge i_clock);
                for (int l = 0; l < 7; l++) ccv[16*l +: 16] <= 16'(g*4096 + k*256 + l*16 + 5);
                ccw <= 7'(1 << k);
                @(posedge i_clock);
                ccw <= 7'h00;
                pulse(4'h0, 0);
                for (int l = 0; l < 7; l++) begin
                    if (ctrl(g, l) == k) exp_l[l] = ccv[16*l +: 16];
                    chk(o_compare_shadow_latch[16*l +: 16], exp_l[l]);
                end
            end
        end
        // Period 5 in latch 0; latch 2 reloads when the count reaches zero
        wr(6'h00, 16'h0000);
        @(posedge i_clock);
        ccv[15:0]  <= 16'h0005;
        ccv[47:32] <= 16'h0abc;
        lsel       <= 14'h0010;
        ccw        <= 7'h01;
        @(posedge i_clock);
        ccw <= 7'h00;
        pulse(4'h0, 0);
        chk(o_compare_shadow_latch[15:0], 16'h0005);
        wr(6'h00, 16'h0016);
        pulse(4'h1, 5);
        chk(o_counter_value, 16'h0005);
        pulse(4'h1, 1);
        chk(o_counter_value, 16'h0000);
        chk(o_overflow_irq_request, 16'h0001);
        chk(o_compare_shadow_latch[47:32], 16'h0abc);
        // Up/down turns at the period and at zero; latch 3 reloads at the period,
        // latch 4 (preloaded with 3) reloads when the count reaches its own value
        @(posedge i_clock);
        ccv[63:48] <= 16'h0def;
        ccv[79:64] <= 16'h0003;
        ccw        <= 7'h10;
        @(posedge i_clock);
        ccw        <= 7'h00;
        ccv[79:64] <= 16'h0777;
        lsel       <= 14'h0390;
        wr(6'h00, 16'h0036);
        pulse(4'h1, 5);
        chk(o_counter_value, 16'h0005);
        chk(o_compare_shadow_latch[63:48], 16'h0def);
        chk(o_compare_shadow_latch[79:64], 16'h0777);
        pulse(4'h1, 3);
        chk(o_counter_value, 16'h0002);
        pulse(4'h1, 2);
        chk(o_counter_value, 16'h0000);
        chk(o_overflow_irq_request, 16'h0001);
        pulse(4'h1, 1);
        chk(o_counter_value, 16'h0001);
        // Clear while counting down must restore the upward direction
        pulse(4'h1, 6);
        chk(o_counter_value, 16'h0003);
        wr(6'h00, 16'h0034);
        pulse(4'h0, 0);
        chk(o_counter_value, 16'h0000);
        wr(6'h10, 16'h0003);
        pulse(4'h1, 1);
        chk(o_counter_value, 16'h0004);
        // Clear must also empty a half-filled divide-by-2 stage
        wr(6'h00, 16'h0074);
        pulse(4'h1, 1);
        chk(o_counter_value, 16'h0000);
        wr(6'h00, 16'h0074);
        pulse(4'h1, 1);
        chk(o_counter_value, 16'h0000);
        pulse(4'h1, 1);
        chk(o_counter_value, 16'h0001);
        // Second reset in mid-run
        @(posedge i_clock);
        i_srst <= 1'b1;
        repeat (2) @(posedge i_clock);
        i_srst <= 1'b0;
        #1;
        chk(o_counter_value, 16'h0000);
        chk(o_compare_shadow_latch[15:0], 16'h0000);
        chk(o_overflow_irq_request, 16'h0000);
        rd(6'h00);
        chk(rd_val, 16'h0000);
        rd(6'h10);
        chk(rd_val, 16'h0000);
        tally_and_finish();
    end

endmodule
